// ---- rtl/bds_pkg.sv ----
/*
  bds_pkg: register map, field positions, reset values, timing counts and carrier
  types for the bridge driver supervision block.
  assumes a 200 MHz pclk; all timing counts are derived from CLK_PERIOD_NS.
*/
package bds_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 5;
  localparam int GUARD_BASE_NS    = 587;   // guard and blank offset
  localparam int GUARD_STEP_NS    = 266;   // guard and blank step per code
  localparam int FILT0_NS         = 500;   // vds filter choices
  localparam int FILT1_NS         = 1000;
  localparam int FILT2_NS         = 2000;
  localparam int FILT3_NS         = 6000;
  localparam int PUMP_BLANK_NS    = 10000; // pump undervoltage blanking
  localparam int BRK_BLANK1_NS    = 1000;  // brake blank, select 0
  localparam int BRK_BLANK2_NS    = 4000;  // brake blank, select 1
  localparam int BRK_FILT_NS      = 2000;  // brake vds filter
  localparam int OV_FILT_NS       = 5000;  // overvoltage brake release filter
  // cycles, least times rounded up
  localparam int PUMP_BLANK_CYC   = (PUMP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BRK_BLANK1_CYC   = (BRK_BLANK1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BRK_BLANK2_CYC   = (BRK_BLANK2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BRK_FILT_CYC     = (BRK_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OV_FILT_CYC      = (OV_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONFIG      = 8'h00;
  localparam logic [7:0] ADDR_BRIDGE      = 8'h04;
  localparam logic [7:0] ADDR_GUARD_BLANK = 8'h08;
  localparam logic [7:0] ADDR_STATUS      = 8'h0c;
  localparam logic [7:0] ADDR_LIVE        = 8'h10;
  localparam logic [31:0] CONFIG_RESET      = 32'h0000_0000;
  localparam logic [31:0] BRIDGE_RESET      = 32'h0000_0000;
  localparam logic [31:0] GUARD_BLANK_RESET = 32'h0000_0000;

  // config fields
  localparam int F_PUMP_EN   = 0;
  localparam int F_GATE_LVL  = 1;
  localparam int F_UV_LVL    = 2;
  localparam int F_OVERVOLTAGE_BRAKE_ENABLE = 3;
  localparam int F_SLAM_EN   = 4;
  localparam int F_PARK_EN   = 5;
  localparam int F_BRK_VDS   = 6;
  localparam int F_BRK_BLK   = 7;
  localparam int F_SENSE_DIR = 8;
  localparam int F_GAIN      = 9;   // two bits
  localparam int F_OC_LVL    = 11;  // two bits
  localparam int F_AFW       = 13;  // three bits
  localparam int F_PWM_EN    = 16;  // three bits
  localparam int F_SLAM_DIS  = 19;  // three bits
  // bridge fields: state at 2*i, filter select at 6
  localparam int F_FILT_SEL  = 6;
  // guard/blank fields: bridge i at 8*i, guard low nibble, blank high nibble
  // status fields (write one to clear)
  localparam int F_VDS_FLT   = 0;   // three bits
  localparam int F_BRK_FLT   = 3;   // three bits
  localparam int F_VS_BRK    = 6;
  localparam int F_VSINT_BRK = 7;
  localparam int F_PUMP_UV   = 8;
  localparam int F_OUT_LVL   = 10;  // three bits, read only

  // ----------------------------------------------------------------
  // codes and carriers
  // ----------------------------------------------------------------
  localparam logic [1:0] SIDE_NONE = 2'h0;
  localparam logic [1:0] SIDE_HS   = 2'h1;
  localparam logic [1:0] SIDE_LS   = 2'h2;
  localparam logic [1:0] HB_FLOAT  = 2'h0;
  localparam logic [1:0] HB_LS_ON  = 2'h1;
  localparam logic [1:0] HB_HS_ON  = 2'h2;
  localparam logic [1:0] HB_OFF    = 2'h3;

  typedef enum logic [1:0] {
    BR_OFF   = 2'b00,
    BR_GUARD = 2'b01,
    BR_ON    = 2'b10
  } bds_phase_t;

  // pins from the analog side, all asynchronous to pclk
  typedef struct packed {
    logic [2:0] vds_over_hs;
    logic [2:0] vds_over_ls;
    logic [2:0] out_level;
    logic [2:0] pwm_in;
    logic       pump_uv;
    logic       vs_over_brake;
    logic       vsint_over_brake;
    logic       supplies_below_hyst;
    logic       slam_trigger_input;
    logic       sleep_stop_mode;
    logic       supply_fault;
  } bds_pins_t;

  // analog settings driven out of the block
  typedef struct packed {
    logic       sense_direction_select;
    logic [1:0] sense_gain_select;
    logic [1:0] overcurrent_level_select;
    logic [1:0] pump_uv_level_code;
    logic       brake_vds_level;
  } bds_analog_t;
endpackage

// ---- rtl/bds_supervisor.sv ----
/*
  bds_supervisor: supervision logic for three half-bridge gate drivers, with its
  apb register slave.
  assumes the analog comparators and pin levels are asynchronous to pclk and
  that the gate driver stages act on the registered on and discharge outputs.
*/
// Decided for this implementation: the register addresses and the APB register port.
// Notes on behaviour
// - never both transistors of a bridge on
// - blank interval masks vds fault detection
// - guard and blank: 587 ns plus 266 ns per code
// - pwm freewheel: blank starts after guard expiry
// - static: blank after guard, or immediately from float
// - fresh blank on every transistor activation; a brake low-side delayed by its guard gets the blank begun at brake start
// - pull-up on when pump enabled and bridge active
// - output level flag only in state 11 with pump
// - two select bits pick pump uv threshold
// - pump uv: discharge, drivers off, latch flag
// - uv flag clears on a software clear written after recovery
// - pump uv ignored after each pump activation
// - low-sides brake with pump off, three causes
// - brake vds monitored after selected brake blank
// - brake vds fault latches all low-sides off
// - brake fault keeps low-sides and pump off
// - overvoltage brake: low-sides on, latch flag
// - brake ends after filter, or on vds fault
// - sense direction and gain select passed out
// - overcurrent level code passed to comparator
// - vds fault after blank and filter time
// - faulted bridge stays off until cleared
`timescale 1ns/1ps
module bds_supervisor
  import bds_pkg::*;
#(
  parameter int NUM_HB = 3
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // analog and pin inputs
  input  wire bds_pins_t   pins,
  // gate driver controls
  output logic [2:0]       hs_on,
  output logic [2:0]       ls_on,
  output logic [2:0]       discharge_on,
  output logic [2:0]       pullup_on,
  output logic             pump_run,
  output logic             sense_amp_en,
  output bds_analog_t      analog
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // guard or blank length in cycles for a 4-bit code, rounded up
  function automatic logic [11:0] code_cycles(input logic [3:0] code);
    int ns;
    ns = GUARD_BASE_NS + GUARD_STEP_NS * int'(code);
    return 12'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  // vds filter length for the two-bit filter select
  function automatic logic [11:0] filt_cycles(input logic [1:0] sel);
    int ns;
    unique case (sel)
      2'h0: ns = FILT0_NS;
      2'h1: ns = FILT1_NS;
      2'h2: ns = FILT2_NS;
      2'h3: ns = FILT3_NS;
    endcase
    return 12'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    bds_pins_t                 pin1;         // synchroniser first stage
    bds_pins_t                 pin2;         // synchroniser second stage
    logic [31:0]               cfg;          // config register
    logic [31:0]               bridge;       // bridge states and filter select
    logic [31:0]               gb;           // guard and blank codes
    logic [2:0]                vds_fault;    // sticky per-bridge vds faults
    logic [2:0]                brk_fault;    // sticky low-side brake faults
    logic                      vs_brk;       // sticky supply brake flag
    logic                      vsint_brk;    // sticky internal supply brake flag
    logic                      uv_flag;      // sticky pump undervoltage
    bds_phase_t [2:0]          phase;        // per-bridge sequencer
    logic [2:0][1:0]           side;         // side currently on
    logic [2:0][1:0]           tgt;          // side wanted after guard
    logic [2:0][11:0]          cnt;          // guard or blank counter
    logic [2:0][11:0]          filt;         // vds filter counter
    logic                      pump;         // pump running
    logic [11:0]               pump_blank;   // uv blanking counter
    logic                      brake;        // braking active
    logic [11:0]               brk_blank;    // brake blank counter
    logic [11:0]               brk_filt;     // brake vds filter counter
    logic                      ov_act;       // overvoltage brake active
    logic [11:0]               ov_filt;      // release filter counter
    logic [2:0]                hs;           // registered gate outputs
    logic [2:0]                ls;
    logic [2:0]                dis;
    logic [2:0]                pull;
    logic                      ready;        // apb answer
    logic                      err;
    logic [31:0]               rdata;
  } bds_state_t;

  bds_state_t st;        // current state
  bds_state_t next_st;   // next state

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic        wr;         // write taken this edge
    logic        clr;        // status write-one-to-clear taken
    logic [1:0]  want;       // wanted side of a bridge
    logic [1:0]  mode;       // bridge state code
    logic        over;       // vds over on the active side
    logic        pump_req;   // pump allowed to run
    logic        brk_req;    // any braking cause
    logic        brk_ls_ok;  // brake low-side vds over on any bridge
    logic        slam_only;  // braking caused by slam alone
    logic [2:0]  brk_ls;     // low-sides driven by the brake
    logic [31:0] rd;         // read mux
    logic        hit;        // mapped address
    next_st   = st;
    wr        = 1'b0;
    clr       = 1'b0;
    want      = SIDE_NONE;
    mode      = HB_FLOAT;
    over      = 1'b0;
    pump_req  = 1'b0;
    brk_req   = 1'b0;
    brk_ls_ok = 1'b0;
    slam_only = 1'b0;
    brk_ls    = 3'h0;
    rd        = 32'h0000_0000;
    hit       = 1'b1;

    // two-flop synchronisers; only pin2 is read below
    next_st.pin1 = pins;
    next_st.pin2 = st.pin1;

    // apb: setup cycle prepares the answer, access cycle finds pready high
    unique case (paddr)
      ADDR_CONFIG:      rd = st.cfg;
      ADDR_BRIDGE:      rd = st.bridge;
      ADDR_GUARD_BLANK: rd = st.gb;
      ADDR_STATUS: begin
        rd[F_VDS_FLT +: 3]   = st.vds_fault;
        rd[F_BRK_FLT +: 3]   = st.brk_fault;
        rd[F_VS_BRK]         = st.vs_brk;
        rd[F_VSINT_BRK]      = st.vsint_brk;
        rd[F_PUMP_UV]        = st.uv_flag;
        for (int i = 0; i < NUM_HB; i++) begin
          // level readback only when actively off with the pump enabled
          rd[F_OUT_LVL + i] = st.cfg[F_PUMP_EN] && st.bridge[2*i +: 2] == HB_OFF
                              && st.pin2.out_level[i];
        end
      end
      ADDR_LIVE:        rd = {20'h0, st.brake, st.pump, st.dis, st.ls, st.hs, st.ov_act};
      default: begin
        rd  = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    next_st.ready = psel && !penable;
    next_st.err   = psel && !penable && !hit;
    next_st.rdata = (psel && !penable && !pwrite) ? rd : 32'h0000_0000;
    wr  = psel && penable && st.ready && pwrite;
    clr = wr && paddr == ADDR_STATUS;
    if (wr && paddr == ADDR_CONFIG) begin
      next_st.cfg = pwdata & 32'h003f_ffff;
    end
    if (wr && paddr == ADDR_BRIDGE) begin
      next_st.bridge = pwdata & 32'h0000_00ff;
    end
    if (wr && paddr == ADDR_GUARD_BLANK) begin
      // software keeps pwm off while changing these
      next_st.gb = pwdata & 32'h00ff_ffff;
    end

    // status clears first; hardware sets below win over them
    if (clr) begin
      next_st.vds_fault = st.vds_fault & ~pwdata[F_VDS_FLT +: 3];
      next_st.brk_fault = st.brk_fault & ~pwdata[F_BRK_FLT +: 3];
      next_st.vs_brk    = st.vs_brk && !pwdata[F_VS_BRK];
      next_st.vsint_brk = st.vsint_brk && !pwdata[F_VSINT_BRK];
      // uv flag clears only once the pump voltage has recovered
      if (pwdata[F_PUMP_UV] && !st.pin2.pump_uv) begin
        next_st.uv_flag = 1'b0;
      end
    end

    // pump: held off by brake faults, uv latch and supply faults
    pump_req = st.cfg[F_PUMP_EN] && st.brk_fault == 3'h0
               && !st.uv_flag && !st.pin2.supply_fault;
    next_st.pump = pump_req;
    if (pump_req && !st.pump) begin
      next_st.pump_blank = 12'(PUMP_BLANK_CYC);
    end else if (st.pump_blank != 12'h000) begin
      next_st.pump_blank = st.pump_blank - 12'h001;
    end
    if (st.pump && st.pump_blank == 12'h000 && st.pin2.pump_uv) begin
      next_st.uv_flag = 1'b1;
      next_st.pump    = 1'b0;
    end

    // per-bridge sequencer
    for (int i = 0; i < NUM_HB; i++) begin
      mode = st.bridge[2*i +: 2];
      want = SIDE_NONE;
      if (st.pump && !st.vds_fault[i]) begin
        unique case (mode)
          HB_LS_ON: begin
            if (!st.cfg[F_PWM_EN + i] || st.pin2.pwm_in[i]) begin
              want = SIDE_LS;
            end else if (st.cfg[F_AFW + i]) begin
              want = SIDE_HS;
            end
          end
          HB_HS_ON: begin
            if (!st.cfg[F_PWM_EN + i] || st.pin2.pwm_in[i]) begin
              want = SIDE_HS;
            end else if (st.cfg[F_AFW + i]) begin
              want = SIDE_LS;
            end
          end
          HB_FLOAT, HB_OFF: want = SIDE_NONE;
        endcase
      end
      unique case (st.phase[i])
        BR_OFF: begin
          if (want != SIDE_NONE && st.ls[i]) begin
            // a brake low-side is still on: discharge it for the guard first
            next_st.phase[i] = BR_GUARD;
            next_st.tgt[i]   = want;
            next_st.cnt[i]   = code_cycles(st.gb[8*i +: 4]);
          end else if (want != SIDE_NONE) begin
            // from float the blank starts at once
            next_st.phase[i] = BR_ON;
            next_st.side[i]  = want;
            next_st.cnt[i]   = code_cycles(st.gb[8*i+4 +: 4]);
            next_st.filt[i]  = 12'h000;
          end
        end
        BR_ON: begin
          if (want != st.side[i]) begin
            // switch off, discharge for the guard before anything else
            next_st.phase[i] = BR_GUARD;
            next_st.tgt[i]   = want;
            next_st.cnt[i]   = code_cycles(st.gb[8*i +: 4]);
          end else if (st.cnt[i] != 12'h000) begin
            next_st.cnt[i]  = st.cnt[i] - 12'h001;
            next_st.filt[i] = 12'h000;
          end else begin
            over = (st.side[i] == SIDE_HS) ? st.pin2.vds_over_hs[i] : st.pin2.vds_over_ls[i];
            if (!over) begin
              next_st.filt[i] = 12'h000;
            end else if (st.filt[i] >= filt_cycles(st.bridge[F_FILT_SEL +: 2])) begin
              next_st.vds_fault[i] = 1'b1;
              next_st.phase[i]     = BR_GUARD;
              next_st.tgt[i]       = SIDE_NONE;
              next_st.cnt[i]       = code_cycles(st.gb[8*i +: 4]);
            end else begin
              next_st.filt[i] = st.filt[i] + 12'h001;
            end
          end
        end
        BR_GUARD: begin
          next_st.tgt[i] = want;
          if (st.cnt[i] != 12'h000) begin
            next_st.cnt[i] = st.cnt[i] - 12'h001;
          end else if (want == SIDE_NONE) begin
            next_st.phase[i] = BR_OFF;
            next_st.side[i]  = SIDE_NONE;
          end else begin
            // the blank of the new side starts at guard expiry
            next_st.phase[i] = BR_ON;
            next_st.side[i]  = want;
            next_st.cnt[i]   = code_cycles(st.gb[8*i+4 +: 4]);
            next_st.filt[i]  = 12'h000;
          end
        end
        default: next_st.phase[i] = BR_OFF;
      endcase
      // high-side on only in the on phase, so the two sides never overlap
      next_st.hs[i]   = next_st.phase[i] == BR_ON && next_st.side[i] == SIDE_HS;
      next_st.dis[i]  = next_st.phase[i] == BR_GUARD;
      next_st.pull[i] = st.cfg[F_PUMP_EN] && mode != HB_FLOAT;
    end

    // overvoltage brake: set on any supply over, release after filter
    if (st.cfg[F_OVERVOLTAGE_BRAKE_ENABLE] && (st.pin2.vs_over_brake || st.pin2.vsint_over_brake)) begin
      next_st.ov_act  = 1'b1;
      next_st.ov_filt = 12'h000;
    end else if (!st.cfg[F_OVERVOLTAGE_BRAKE_ENABLE]) begin
      next_st.ov_act  = 1'b0;
      next_st.ov_filt = 12'h000;
    end else if (st.ov_act && st.pin2.supplies_below_hyst) begin
      if (st.ov_filt >= 12'(OV_FILT_CYC)) begin
        next_st.ov_act  = 1'b0;
        next_st.ov_filt = 12'h000;
      end else begin
        next_st.ov_filt = st.ov_filt + 12'h001;
      end
    end else begin
      next_st.ov_filt = 12'h000;
    end
    if (st.cfg[F_OVERVOLTAGE_BRAKE_ENABLE] && st.pin2.vs_over_brake) begin
      next_st.vs_brk = 1'b1;
    end
    if (st.cfg[F_OVERVOLTAGE_BRAKE_ENABLE] && st.pin2.vsint_over_brake) begin
      next_st.vsint_brk = 1'b1;
    end

    // braking causes, only with the pump off
    slam_only = st.cfg[F_SLAM_EN] && st.pin2.slam_trigger_input
                && !(st.cfg[F_PARK_EN] && st.pin2.sleep_stop_mode) && !st.ov_act;
    brk_req = !st.pump && st.brk_fault == 3'h0 &&
              ((st.cfg[F_SLAM_EN] && st.pin2.slam_trigger_input) ||
               (st.cfg[F_PARK_EN] && st.pin2.sleep_stop_mode) || st.ov_act);
    next_st.brake = brk_req;
    if (brk_req && !st.brake) begin
      next_st.brk_blank = st.cfg[F_BRK_BLK] ? 12'(BRK_BLANK2_CYC) : 12'(BRK_BLANK1_CYC);
      next_st.brk_filt  = 12'h000;
    end else if (st.brk_blank != 12'h000) begin
      next_st.brk_blank = st.brk_blank - 12'h001;
    end
    brk_ls = slam_only ? ~st.cfg[F_SLAM_DIS +: 3] : 3'h7;
    brk_ls_ok = |(st.pin2.vds_over_ls & st.ls);
    if (st.brake && st.brk_blank == 12'h000 && brk_ls_ok) begin
      if (st.brk_filt >= 12'(BRK_FILT_CYC)) begin
        // latch every low-side off; mode bits stay untouched
        next_st.brk_fault = next_st.brk_fault | (st.pin2.vds_over_ls & st.ls);
        next_st.brake     = 1'b0;
        next_st.brk_filt  = 12'h000;
      end else begin
        next_st.brk_filt = st.brk_filt + 12'h001;
      end
    end else begin
      next_st.brk_filt = 12'h000;
    end
    // a brake low-side waits until its bridge has finished its guard
    for (int i = 0; i < NUM_HB; i++) begin
      next_st.ls[i] = next_st.brake ? (brk_ls[i] && next_st.phase[i] == BR_OFF) :
                      (next_st.phase[i] == BR_ON && next_st.side[i] == SIDE_LS);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st        <= '0;
      st.cfg    <= CONFIG_RESET;
      st.bridge <= BRIDGE_RESET;
      st.gb     <= GUARD_BLANK_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign pready       = st.ready;
  assign prdata       = st.rdata;
  assign pslverr      = st.err;
  assign hs_on        = st.hs;
  assign ls_on        = st.ls;
  assign discharge_on = st.dis;
  assign pullup_on    = st.pull;
  assign pump_run     = st.pump;
  assign sense_amp_en = st.pump;
  assign analog.sense_direction_select   = st.cfg[F_SENSE_DIR];
  assign analog.sense_gain_select        = st.cfg[F_GAIN +: 2];
  assign analog.overcurrent_level_select = st.cfg[F_OC_LVL +: 2];
  assign analog.pump_uv_level_code       = {st.cfg[F_GATE_LVL], st.cfg[F_UV_LVL]};
  assign analog.brake_vds_level          = st.cfg[F_BRK_VDS];

endmodule

// ---- sim/bds_supervisor_sva.sv ----
/* bds_sva: port-level assertions for the bridge supervisor.
   assumes it is bound to bds_supervisor; pclk and presetn are its only domain. */
`timescale 1ns/1ps
module bds_sva
  import bds_pkg::*;
(
  // clock, reset and apb
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata, prdata,
  // driver side
  input wire logic [2:0]  hs_on, ls_on, discharge_on,
  input wire logic        pump_run, sense_amp_en,
  input wire bds_analog_t analog
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // config bits in the order the analog carrier packs them
  wire logic [7:0] cfg_map = {pwdata[8], pwdata[10:9], pwdata[12:11], pwdata[1], pwdata[2], pwdata[6]};
  sequence s_cfg_wr;
    psel && penable && pready && pwrite && paddr == ADDR_CONFIG;
  endsequence
  a_no_cross: assert property ((hs_on & ls_on) == 3'h0) else $error("both sides on");
  // the shortest guard is far above eight cycles
  a_guard_gap: assert property ($fell(ls_on[0]) |-> (!hs_on[0]) [*8]) else $error("no guard");
  a_guard_hs: assert property ($fell(hs_on[0]) |-> (!ls_on[0]) [*8]) else $error("no guard after hs");
  a_rdy_setup: assert property (psel && !penable |=> pready) else $error("late pready");
  a_rdy_single: assert property (pready |=> !pready) else $error("long pready");
  a_err_map: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > ADDR_LIVE))
    else $error("bad pslverr");
  a_rd_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  a_csa_pump: assert property (sense_amp_en == pump_run) else $error("sense amp apart");
  a_cfg_out: assert property (s_cfg_wr |=> analog == $past(cfg_map)) else $error("analog");
  a_uv_off: assert property ($fell(pump_run) |-> ##[0:1000] (hs_on == 3'h0 && discharge_on == 3'h0))
    else $error("drivers stay on");
endmodule

// ---- sim/bds_bridge_model.sv ----
/* bds_bridge_model: external half-bridges as the comparators see them.
   assumes the bench commands shorts; outputs feed the pin carrier. */
`timescale 1ns/1ps
module bds_bridge_model (
  // gate drive and fault commands
  input  wire logic       pclk,
  input  wire logic [2:0] hs_on, ls_on, pullup_on, short_hs, short_ls,
  // comparator and level pins
  output logic [2:0]      vds_over_hs, vds_over_ls, out_level
);
  logic tgl; // a floating node wanders, so it may not read as a clean 0
  initial tgl = 1'b0;
  always_ff @(posedge pclk) tgl <= ~tgl;
  assign vds_over_hs = hs_on & short_hs;
  assign vds_over_ls = ls_on & short_ls;
  assign out_level = ((hs_on | pullup_on) & ~ls_on) | ({3{tgl}} & ~(hs_on | ls_on | pullup_on));
endmodule

// ---- sim/tb_bridge_driver_supervision.sv ----
/* tb_bridge_driver_supervision: apb driven scenarios for the supervisor.
   assumes bds_pkg, the checker and the bridge model are compiled first. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_bridge_driver_supervision;
  import bds_pkg::*;
  localparam int G = (GUARD_BASE_NS + 2 * GUARD_STEP_NS + 4) / 5; // guard and blank, code 2
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pump_run, sense_amp_en, uv, slam, rerr, sf;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [2:0]  hs_on, ls_on, discharge_on, pullup_on, short_hs, short_ls, vds_over_hs, vds_over_ls, out_level;
  logic [1:0]  k;
  bds_pins_t   pins;
  bds_analog_t analog;
  int          err_count = 0, num_checks = 0;
  // supply fault driven on its own; pwm, brake supplies and sleep tied
  assign pins = {vds_over_hs, vds_over_ls, out_level, 3'h0, uv, 3'b001, slam, 1'b0, sf};
  bds_supervisor DUT (.*);
  bds_bridge_model model (.*);
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // one apb transfer; read data and error taken at the pready edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic give_verdict;
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, uv, slam, short_hs, short_ls, sf, presetn} = '0;
    wt(10);
    presetn <= 1'b1;
    xfer(0, ADDR_CONFIG, 0); `CHK("config reset", CONFIG_RESET, rdat)
    xfer(0, 8'h14, 0); `CHK("unmapped", 1'b1, rerr)
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      xfer(1, ADDR_CONFIG, {19'h0, k, k, k[0], 5'h0, k[0], k[1], 1'b1});
      wt(1); `CHK("analog", {k[0], k, k, k, 1'b0}, analog)
    end
    `CHK("pump", 1'b1, pump_run)
    xfer(1, ADDR_GUARD_BLANK, 32'h22);
    xfer(1, ADDR_BRIDGE, 32'h31); wt(4); `CHK("ls float", 3'b001, ls_on)
    `CHK("pullup", 3'b101, pullup_on)
    xfer(0, ADDR_STATUS, 0); `CHK("level", 3'b100, rdat[12:10])
    xfer(1, ADDR_BRIDGE, 32'h32); wt(G - 20); `CHK("guard", 2'b01, {hs_on[0], discharge_on[0]})
    wt(40); `CHK("hs", 1'b1, hs_on[0])
    short_hs <= 3'b001; wt(150); `CHK("blank", 1'b1, hs_on[0])
    wt(G); `CHK("trip", 1'b0, hs_on[0])
    xfer(0, ADDR_STATUS, 0); `CHK("vds flag", 1'b1, rdat[0])
    short_hs <= 3'b000; wt(4); `CHK("held", 1'b0, hs_on[0])
    xfer(1, ADDR_STATUS, 32'h1); wt(G); `CHK("again", 1'b1, hs_on[0])
    uv <= 1'b1; wt(8); `CHK("uv blank", 1'b1, pump_run)
    wt(PUMP_BLANK_CYC + G); `CHK("uv", 4'h0, {pump_run, hs_on})
    xfer(1, ADDR_STATUS, 32'h100); xfer(0, ADDR_STATUS, 0); `CHK("uv kept", 1'b1, rdat[8])
    uv <= 1'b0; wt(4); xfer(1, ADDR_STATUS, 32'h100); xfer(0, ADDR_STATUS, 0);
    `CHK("uv clr", 1'b0, rdat[8])
    wt(4); `CHK("pump back", 1'b1, pump_run)
    sf <= 1'b1; wt(4); `CHK("sup off", 1'b0, pump_run)
    sf <= 1'b0; wt(4); `CHK("sup back", 1'b1, pump_run)
    xfer(1, ADDR_CONFIG, 32'h10); slam <= 1'b1; wt(G + 20); `CHK("slam", 3'b111, ls_on)
    short_ls <= 3'b010; wt(BRK_BLANK1_CYC + BRK_FILT_CYC + 20); `CHK("brk", 3'h0, ls_on)
    xfer(0, ADDR_STATUS, 0); `CHK("brk flag", 3'b010, rdat[5:3])
    xfer(1, ADDR_CONFIG, 32'h11); wt(4); `CHK("pump hold", 1'b0, pump_run)
    short_ls <= 3'b000; xfer(1, ADDR_STATUS, 32'h38); wt(4); `CHK("pump free", 1'b1, pump_run)
    give_verdict;
  end
  initial begin
    wt(12000);
    err_count++;
    give_verdict;
  end
endmodule
bind bds_supervisor bds_sva chk (.*);
